//--- design/synth_offset_afc_pkg.sv
// synth_offset_afc_pkg: register map, field positions, reset values and scale constants
// assumes an 8-bit register port driven by the device's SPI front end
package synth_offset_afc_pkg;

  // ==========================================================
  // register offsets
  localparam logic [6:0] ADDR_AFC_LOOP_CONTROL  = 7'h1D;
  localparam logic [6:0] ADDR_OPERATING_MODE    = 7'h07;
  localparam logic [6:0] ADDR_MOD_CONTROL_TWO   = 7'h71;
  localparam logic [6:0] ADDR_DEVIATION_LOW     = 7'h72;
  localparam logic [6:0] ADDR_OFFSET_LOW        = 7'h73;
  localparam logic [6:0] ADDR_OFFSET_HIGH       = 7'h74;
  localparam logic [6:0] ADDR_BAND_SELECT       = 7'h75;
  localparam logic [6:0] ADDR_HOP_CHANNEL       = 7'h79;
  localparam logic [6:0] ADDR_HOP_STEP          = 7'h7A;
  localparam logic [6:0] ADDR_RECEIVE_FIFO_PORT = 7'h7F;

  // ==========================================================
  // reset values
  localparam logic [7:0] RST_AFC_LOOP_CONTROL = 8'h40;
  localparam logic [7:0] RST_MOD_CONTROL_TWO  = 8'h00;
  localparam logic [7:0] RST_DEVIATION_LOW    = 8'h43;
  localparam logic [7:0] RST_OFFSET           = 8'h00;
  localparam logic [7:0] RST_BAND_SELECT      = 8'h35;
  localparam logic [7:0] RST_OPERATING_MODE   = 8'h01;

  // ==========================================================
  // field positions
  localparam int AFC_RANGE_HALVE_BIT  = 7;
  localparam int AFC_ENABLE_BIT       = 6;
  localparam int DEVIATION_MSB_BIT    = 2;
  localparam int HIGH_BAND_SELECT_BIT = 5;
  localparam int RECEIVE_ON_BIT       = 2;
  localparam int TRANSMIT_ON_BIT      = 3;
  localparam int MODULATION_TYPE_LSB  = 0;
  localparam logic [1:0] MOD_TYPE_UNMODULATED = 2'h0;

  // ==========================================================
  // scale figures: steps in millihertz, ranges in kilohertz
  localparam int DEVIATION_STEP_MHZ  = 625000;
  localparam int OFFSET_STEP_MHZ     = 156250;
  localparam int DEVIATION_MIN_KHZ   = 1;
  localparam int DEVIATION_MAX_KHZ   = 320;
  localparam int OFFSET_RANGE_HB_KHZ = 160;
  localparam int OFFSET_RANGE_LB_KHZ = 80;

  // ==========================================================
  // widths
  localparam int DEVIATION_WIDTH = 9;
  localparam int OFFSET_WIDTH    = 10;

  typedef enum logic [1:0]
  {
    RADIO_IDLE = 2'b00,
    RADIO_TUNE = 2'b01,
    RADIO_TX   = 2'b10,
    RADIO_RX   = 2'b11
  } radio_state_type;

  typedef struct packed
  {
    logic       write;
    logic       read;
    logic [6:0] addr;
    logic [7:0] wdata;
  } reg_request_type;

  typedef struct packed
  {
    logic preamble_detect;
    logic packet_end;
    logic packet_valid;
    logic packet_error;
  } modem_event_type;

endpackage

//--- design/synth_offset_afc_control.sv
// synth_offset_afc_control: frequency correction control for the fractional-N synthesizer
// assumes register requests and modem events arrive synchronous to i_clock
//
// What this block does
// R1: hop channel or step write in transmit sends the state machine back to tune
// R2: peak deviation is the nine-bit deviation code times 625 Hz, any band
// R3: deviation range spans plus or minus 1 kHz up to 320 kHz
// R4: deviation MSB lives in 71h bit 2, low eight bits in 72h
// R5: modulation can be switched off for a plain carrier at channel center
// R6: with correction off the ten-bit offset code is signed two's complement
// R7: offset equals code times 156.25 Hz times band factor, shifting the oscillator
// R8: manual offset range is 160 kHz high band, 80 kHz low band
// R9: with correction on, offset reads return the loop's current value
// R10: host reads loop offset only after preamble or sync detect
// R11: the loop retunes the PLL and freezes once preamble is detected
// R12: in multi-packet reception the loop resets at every packet end
// R13: loop resets when correction exceeds twice deviation high band, once low band
// R14: the range halve bit halves the drift limit for that reset
// R15: enable bit selects loop or manual offset; on after reset
// R16: the far transmitter sends a preamble long enough for the loop
// R17: in FIFO mode received data is read from register 7Fh
// R18: FIFO mode leaves receive on packet valid, receive_on cleared only then
// R19: CRC, header or sync errors raise an event but receive continues
// R20: high band select picks high band at one, low band at zero
// R21: the nine-bit deviation code changes as one value after both writes
`timescale 1ns/1ps
module synth_offset_afc_control
  import synth_offset_afc_pkg::*;
(
  // clock and reset
  input  wire logic                          i_clock,
  input  wire logic                          i_nrst,
  // register port
  input  wire reg_request_type               i_request,
  output logic [7:0]                         o_read_data,
  // modem side
  input  wire modem_event_type               i_event,
  input  wire logic                          i_multi_packet,
  input  wire logic                          i_fifo_mode,
  input  wire logic signed [OFFSET_WIDTH-1:0] i_afc_error,
  input  wire logic [7:0]                    i_fifo_data,
  output logic                               o_fifo_pop,
  // synthesizer side
  output logic signed [OFFSET_WIDTH-1:0]     o_lo_offset,
  output logic [DEVIATION_WIDTH-1:0]         o_deviation,
  output logic                               o_modulation_on,
  output logic                               o_high_band,
  output logic                               o_retune,
  output logic                               o_error_event,
  output radio_state_type                    o_state
);

  // ==========================================================
  // registers
  logic [7:0]                         afc_ctrl_q;
  logic [7:0]                         mod_ctrl_q;
  logic [7:0]                         dev_low_q;
  logic [7:0]                         band_q;
  logic [7:0]                         opmode_q;
  // R8 ten bits span the range
  logic [OFFSET_WIDTH-1:0]            manual_offset_q;
  logic signed [OFFSET_WIDTH-1:0]     afc_offset_q;
  logic                               afc_frozen_q;
  // R3 nine bits reach 320 kHz
  logic [DEVIATION_WIDTH-1:0]         deviation_q;
  logic                               dev_msb_pend_q;
  logic                               dev_low_pend_q;
  radio_state_type                    state_q;

  logic                               wr;
  logic                               afc_on;
  logic                               hop_write;
  logic [OFFSET_WIDTH+1:0]            drift_limit;
  logic signed [OFFSET_WIDTH:0]       afc_next;
  logic [OFFSET_WIDTH:0]              afc_mag;
  logic                               drift_reset;

  function automatic logic [OFFSET_WIDTH:0] magnitude(input logic signed [OFFSET_WIDTH:0] v);
    magnitude = v[OFFSET_WIDTH] ? (OFFSET_WIDTH+1)'(0) - v : v;
  endfunction

  assign wr        = i_request.write;
  assign afc_on    = afc_ctrl_q[AFC_ENABLE_BIT];
  assign hop_write = wr && (i_request.addr == ADDR_HOP_CHANNEL || i_request.addr == ADDR_HOP_STEP);

  // ==========================================================
  // configuration registers
  // R15 enable bit reset
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      afc_ctrl_q <= RST_AFC_LOOP_CONTROL;
      mod_ctrl_q <= RST_MOD_CONTROL_TWO;
      dev_low_q  <= RST_DEVIATION_LOW;
      band_q     <= RST_BAND_SELECT;
      manual_offset_q <= {RST_OFFSET[1:0], RST_OFFSET};
    end
    else if (wr)
    begin
      case (i_request.addr)
        ADDR_AFC_LOOP_CONTROL: afc_ctrl_q <= i_request.wdata;
        // R4 deviation MSB register
        ADDR_MOD_CONTROL_TWO:  mod_ctrl_q <= i_request.wdata;
        ADDR_DEVIATION_LOW:    dev_low_q  <= i_request.wdata;
        ADDR_BAND_SELECT:      band_q     <= i_request.wdata;
        // R6 signed offset low and high
        ADDR_OFFSET_LOW:       manual_offset_q[7:0] <= i_request.wdata;
        ADDR_OFFSET_HIGH:      manual_offset_q[9:8] <= i_request.wdata[1:0];
        default:               manual_offset_q <= manual_offset_q;
      endcase
    end
  end

  // ==========================================================
  // deviation: both halves must land before the code changes,
  // so a half-written retune never modulates with a mixed value
  // R21 atomic deviation update
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      deviation_q    <= {RST_MOD_CONTROL_TWO[DEVIATION_MSB_BIT], RST_DEVIATION_LOW};
      dev_msb_pend_q <= 1'b0;
      dev_low_pend_q <= 1'b0;
    end
    else
    begin
      if ((dev_msb_pend_q || (wr && i_request.addr == ADDR_MOD_CONTROL_TWO)) &&
          (dev_low_pend_q || (wr && i_request.addr == ADDR_DEVIATION_LOW)))
      begin
        // R4 nine-bit assembly
        deviation_q <= {(wr && i_request.addr == ADDR_MOD_CONTROL_TWO) ?
                          i_request.wdata[DEVIATION_MSB_BIT] : mod_ctrl_q[DEVIATION_MSB_BIT],
                        (wr && i_request.addr == ADDR_DEVIATION_LOW) ? i_request.wdata : dev_low_q};
        dev_msb_pend_q <= 1'b0;
        dev_low_pend_q <= 1'b0;
      end
      else
      begin
        if (wr && i_request.addr == ADDR_MOD_CONTROL_TWO)
          dev_msb_pend_q <= 1'b1;
        if (wr && i_request.addr == ADDR_DEVIATION_LOW)
          dev_low_pend_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // drift limit in offset steps: deviation step is 4 offset steps,
  // high band offset step doubles so limit 2x dev equals 4*dev steps either band
  // R13 drift limit
  // R14 range halve
  always_comb
  begin
    drift_limit = {1'b0, deviation_q, 2'b00} >> afc_ctrl_q[AFC_RANGE_HALVE_BIT];
  end

  assign afc_next    = {afc_offset_q[OFFSET_WIDTH-1], afc_offset_q} + {i_afc_error[OFFSET_WIDTH-1], i_afc_error};
  assign afc_mag     = magnitude(afc_next);
  // a sum outside ten bits would wrap to the other sign, so it resets as well
  assign drift_reset = ({1'b0, afc_mag} > drift_limit) || (afc_next[OFFSET_WIDTH] != afc_next[OFFSET_WIDTH-1]);

  // ==========================================================
  // correction loop
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      afc_offset_q <= '0;
      afc_frozen_q <= 1'b0;
    end
    // R12 per packet reset
    else if (!afc_on || (i_multi_packet && i_event.packet_end) || state_q != RADIO_RX)
    begin
      afc_offset_q <= '0;
      afc_frozen_q <= 1'b0;
    end
    // R11 freeze on preamble
    // R10 stable for host read
    else if (i_event.preamble_detect)
      afc_frozen_q <= 1'b1;
    else if (!afc_frozen_q)
    begin
      // R13 drift reset
      if (drift_reset)
        afc_offset_q <= '0;
      else
        afc_offset_q <= afc_next[OFFSET_WIDTH-1:0];
    end
  end

  // ==========================================================
  // radio state machine
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      state_q  <= RADIO_IDLE;
      opmode_q <= RST_OPERATING_MODE;
      o_retune <= 1'b0;
    end
    else
    begin
      o_retune <= 1'b0;
      if (wr && i_request.addr == ADDR_OPERATING_MODE)
        opmode_q <= i_request.wdata;
      case (state_q)
        RADIO_IDLE:
        begin
          if (opmode_q[RECEIVE_ON_BIT] || opmode_q[TRANSMIT_ON_BIT])
            state_q <= RADIO_TUNE;
        end
        RADIO_TUNE:
        begin
          if (opmode_q[RECEIVE_ON_BIT])
            state_q <= RADIO_RX;
          else if (opmode_q[TRANSMIT_ON_BIT])
            state_q <= RADIO_TX;
          else
            state_q <= RADIO_IDLE;
        end
        RADIO_TX:
        begin
          // R1 hop retune
          if (hop_write)
          begin
            state_q  <= RADIO_TUNE;
            o_retune <= 1'b1;
          end
          else if (!opmode_q[TRANSMIT_ON_BIT])
            state_q <= RADIO_IDLE;
        end
        RADIO_RX:
        begin
          // R18 exit on packet valid
          if (i_fifo_mode && i_event.packet_valid)
          begin
            state_q <= RADIO_IDLE;
            if (!(wr && i_request.addr == ADDR_OPERATING_MODE))
              opmode_q[RECEIVE_ON_BIT] <= 1'b0;
          end
          else if (hop_write)
          begin
            state_q  <= RADIO_TUNE;
            o_retune <= 1'b1;
          end
        end
        default: state_q <= RADIO_IDLE;
      endcase
    end
  end

  // ==========================================================
  // outputs and readback
  always_ff @(posedge i_clock)
  begin
    if (!i_nrst)
    begin
      o_read_data     <= 8'h00;
      o_fifo_pop      <= 1'b0;
      o_lo_offset     <= '0;
      o_deviation     <= '0;
      o_modulation_on <= 1'b0;
      o_high_band     <= 1'b0;
      o_error_event   <= 1'b0;
      o_state         <= RADIO_IDLE;
    end
    else
    begin
      // R7 offset shifts the LO
      // R15 source select
      o_lo_offset     <= afc_on ? afc_offset_q : manual_offset_q;
      // R2 deviation code out
      o_deviation     <= deviation_q;
      // R5 modulation off
      o_modulation_on <= mod_ctrl_q[MODULATION_TYPE_LSB+:2] != MOD_TYPE_UNMODULATED;
      // R20 band select
      o_high_band     <= band_q[HIGH_BAND_SELECT_BIT];
      // R19 error flags only
      o_error_event   <= i_event.packet_error;
      o_state         <= state_q;
      o_fifo_pop      <= 1'b0;
      o_read_data     <= 8'h00;
      if (i_request.read)
      begin
        case (i_request.addr)
          ADDR_AFC_LOOP_CONTROL: o_read_data <= afc_ctrl_q;
          ADDR_OPERATING_MODE:   o_read_data <= opmode_q;
          ADDR_MOD_CONTROL_TWO:  o_read_data <= mod_ctrl_q;
          ADDR_DEVIATION_LOW:    o_read_data <= dev_low_q;
          ADDR_BAND_SELECT:      o_read_data <= band_q;
          // R9 loop offset readback
          ADDR_OFFSET_LOW:  o_read_data <= afc_on ? afc_offset_q[7:0] : manual_offset_q[7:0];
          ADDR_OFFSET_HIGH: o_read_data <= {6'h00, afc_on ? afc_offset_q[9:8] : manual_offset_q[9:8]};
          // R17 fifo port
          ADDR_RECEIVE_FIFO_PORT:
          begin
            o_read_data <= i_fifo_data;
            o_fifo_pop  <= i_fifo_mode;
          end
          default: o_read_data <= 8'h00;
        endcase
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_hop_in_tx;
    (state_q == RADIO_TX) && hop_write;
  endsequence

  sequence s_back_to_tune;
    (state_q == RADIO_TUNE) && o_retune;
  endsequence

  property p_hop_retune;
    @(posedge i_clock) disable iff (!i_nrst)
    s_hop_in_tx |=> s_back_to_tune;
  endproperty
  a_hop_retune: assert property (p_hop_retune) else $error("hop write did not retune"); // R1

  property p_freeze;
    @(posedge i_clock) disable iff (!i_nrst)
    (afc_frozen_q && afc_on && state_q == RADIO_RX && !i_event.packet_end) |=> $stable(afc_offset_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("loop moved while frozen"); // R11

  property p_packet_reset;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_multi_packet && i_event.packet_end) |=> (afc_offset_q == 0 && !afc_frozen_q);
  endproperty
  a_packet_reset: assert property (p_packet_reset) else $error("loop not reset at packet end"); // R12

  property p_drift;
    @(posedge i_clock) disable iff (!i_nrst)
    ({1'b0, magnitude({afc_offset_q[OFFSET_WIDTH-1], afc_offset_q})} <= drift_limit) || afc_frozen_q || !afc_on;
  endproperty
  a_drift: assert property (p_drift) else $error("loop beyond drift limit"); // R13

  property p_source;
    @(posedge i_clock) disable iff (!i_nrst)
    ##1 (o_lo_offset == ($past(afc_on) ? $past(afc_offset_q) : $past(manual_offset_q)));
  endproperty
  a_source: assert property (p_source) else $error("wrong offset source"); // R15

  property p_rx_exit;
    @(posedge i_clock) disable iff (!i_nrst)
    (state_q == RADIO_RX && i_fifo_mode && i_event.packet_valid) |=> (state_q == RADIO_IDLE);
  endproperty
  a_rx_exit: assert property (p_rx_exit) else $error("no receive exit on packet valid"); // R18

  property p_error_stays;
    @(posedge i_clock) disable iff (!i_nrst)
    (state_q == RADIO_RX && i_event.packet_error && !i_event.packet_valid && !hop_write) |=> state_q == RADIO_RX;
  endproperty
  a_error_stays: assert property (p_error_stays) else $error("error left receive"); // R19

  property p_readback;
    @(posedge i_clock) disable iff (!i_nrst)
    (i_request.read && i_request.addr == ADDR_OFFSET_LOW && afc_on) |=> o_read_data == $past(afc_offset_q[7:0]);
  endproperty
  a_readback: assert property (p_readback) else $error("offset read not loop value"); // R9

endmodule // synth_offset_afc_control

//--- bench/host_model.sv
// host_model: host controller standing on the register port of the correction block
// assumes one access per rising edge and read data registered on the taken edge, sampled at the next falling edge
`timescale 1ns/1ps
module host_model
  import synth_offset_afc_pkg::*;
(
  // clock
  input  wire logic       i_clock,
  // register port
  input  wire logic [7:0] i_read_data,
  output reg_request_type o_request
);
  initial o_request = '0;

  // ==========================================================
  // accesses
  // idle address and data are inverted so a stale value never looks valid
  task automatic write_reg(input logic [6:0] addr, input logic [7:0] data);
    @(negedge i_clock);
    o_request <= '{write: 1'b1, read: 1'b0, addr: addr, wdata: data};
    @(negedge i_clock);
    o_request <= '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~data};
  endtask

  task automatic read_reg(input logic [6:0] addr, output logic [7:0] data);
    @(negedge i_clock);
    o_request <= '{write: 1'b0, read: 1'b1, addr: addr, wdata: ~o_request.wdata};
    @(negedge i_clock);
    data = i_read_data;
    o_request <= '{write: 1'b0, read: 1'b0, addr: ~addr, wdata: ~o_request.wdata};
  endtask
endmodule // host_model

//--- bench/synth_offset_afc_control_tb.sv
// synth_offset_afc_control_tb: register-level tests of the frequency correction block
// assumes host_model for register traffic; modem events are driven here directly
`timescale 1ns/1ps
module synth_offset_afc_control_tb
  import synth_offset_afc_pkg::*;
();
  logic                           i_clock;
  logic                           i_nrst;
  reg_request_type                request;
  logic [7:0]                     read_data;
  modem_event_type                event_in;
  logic                           multi_packet;
  logic                           fifo_mode;
  logic signed [OFFSET_WIDTH-1:0] afc_error;
  logic [7:0]                     fifo_data;
  logic                           fifo_pop;
  logic signed [OFFSET_WIDTH-1:0] lo_offset;
  logic [DEVIATION_WIDTH-1:0]     deviation;
  logic                           modulation_on;
  logic                           high_band;
  logic                           retune;
  logic                           error_event;
  radio_state_type                state;
  int                             fails = 0;
  int                             compares = 0;
  int                             cycles = 0;
  int                             pops = 0;
  int                             errs = 0;
  int                             retunes = 0;
  logic [9:0]                     peak = 10'h000;
  logic [9:0]                     held;
  logic [6:0]                     rst_addr [6] = '{7'h1D, 7'h71, 7'h72, 7'h73, 7'h74, 7'h10};
  logic [7:0]                     rst_val [6] = '{8'h40, 8'h00, 8'h43, 8'h00, 8'h00, 8'h00};

  synth_offset_afc_control i_synth_offset_afc_control
  (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_request(request), .o_read_data(read_data),
    .i_event(event_in), .i_multi_packet(multi_packet), .i_fifo_mode(fifo_mode),
    .i_afc_error(afc_error), .i_fifo_data(fifo_data), .o_fifo_pop(fifo_pop),
    .o_lo_offset(lo_offset), .o_deviation(deviation), .o_modulation_on(modulation_on),
    .o_high_band(high_band), .o_retune(retune), .o_error_event(error_event), .o_state(state)
  );

  host_model i_host_model
  (
    .i_clock(i_clock),
    .i_read_data(read_data),
    .o_request(request)
  );

  // ==========================================================
  // clock, monitors and hang guard
  initial
  begin
    i_clock = 1'b0;
    forever #2 i_clock = ~i_clock;
  end

  always @(posedge i_clock)
  begin
    cycles <= cycles + 1;
    if (fifo_pop === 1'b1) pops <= pops + 1;
    if (error_event === 1'b1) errs <= errs + 1;
    if (retune === 1'b1) retunes <= retunes + 1;
    if ($signed(lo_offset) > $signed(peak)) peak <= lo_offset;
    if (cycles == 4000)
    begin
      fails++;
      conclude();
    end
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      fails++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [6:0] addr, input logic [7:0] data);
    i_host_model.write_reg(addr, data);
  endtask

  task automatic rd_check(input logic [6:0] addr, input logic [7:0] exp);
    logic [7:0] value;
    i_host_model.read_reg(addr, value);
    check({8'h00, value}, {8'h00, exp});
  endtask

  task automatic pulse(input modem_event_type e);
    @(negedge i_clock);
    event_in = e;
    @(negedge i_clock);
    event_in = '0;
  endtask

  task automatic wait_state(input radio_state_type s);
    for (int n = 0; n < 10 && state !== s; n++) @(negedge i_clock);
  endtask

  task automatic conclude();
    $display("compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    i_nrst = 1'b0;
    event_in = '0;
    multi_packet = 1'b0;
    fifo_mode = 1'b0;
    afc_error = 10'h000;
    fifo_data = 8'h00;
    repeat (2) @(negedge i_clock);
    i_nrst = 1'b1;
    for (int k = 0; k < 6; k++) rd_check(rst_addr[k], rst_val[k]);
    check({7'h00, deviation}, 16'h0043);
    check({15'h0000, high_band}, 16'h0001);
    check({15'h0000, modulation_on}, 16'h0000);
    // the top bit alone must not reach the synthesizer
    wr(7'h71, 8'h04);
    repeat (3) @(negedge i_clock);
    check({7'h00, deviation}, 16'h0043);
    wr(7'h72, 8'h20);
    repeat (3) @(negedge i_clock);
    check({7'h00, deviation}, 16'h0120);
    rd_check(7'h71, 8'h04);
    wr(7'h71, 8'h05);
    repeat (2) @(negedge i_clock);
    check({15'h0000, modulation_on}, 16'h0001);
    wr(7'h71, 8'h00);
    wr(7'h72, 8'h20);
    repeat (3) @(negedge i_clock);
    check({15'h0000, modulation_on}, 16'h0000);
    check({7'h00, deviation}, 16'h0020);
    wr(7'h75, 8'h15);
    repeat (2) @(negedge i_clock);
    check({15'h0000, high_band}, 16'h0000);
    wr(7'h75, 8'h35);
    // manual offset of minus 160 codes; reserved bits of the high part read zero
    wr(7'h1D, 8'h00);
    wr(7'h73, 8'h60);
    wr(7'h74, 8'hFF);
    repeat (2) @(negedge i_clock);
    check({6'h00, lo_offset}, 16'h0360);
    rd_check(7'h73, 8'h60);
    rd_check(7'h74, 8'h03);
    fifo_mode = 1'b1;
    fifo_data = 8'hA5;
    rd_check(7'h7F, 8'hA5);
    repeat (2) @(negedge i_clock);
    check(pops[15:0], 16'h0001);
    wr(7'h07, 8'h05);
    wait_state(RADIO_RX);
    check({14'h0000, state}, 16'h0003);
    afc_error = 10'h001;
    repeat (10) @(negedge i_clock);
    check({6'h00, lo_offset}, 16'h0360);
    pulse('{preamble_detect: 1'b0, packet_end: 1'b0, packet_valid: 1'b0, packet_error: 1'b1});
    repeat (2) @(negedge i_clock);
    check(errs[15:0], 16'h0001);
    check({14'h0000, state}, 16'h0003);
    rd_check(7'h07, 8'h05);
    pulse('{preamble_detect: 1'b0, packet_end: 1'b0, packet_valid: 1'b1, packet_error: 1'b0});
    wait_state(RADIO_IDLE);
    check({14'h0000, state}, 16'h0000);
    rd_check(7'h07, 8'h01);
    // transmit: a hop channel write forces one pass through tune
    wr(7'h07, 8'h08);
    wait_state(RADIO_TX);
    check({14'h0000, state}, 16'h0002);
    wr(7'h79, 8'h01);
    repeat (3) @(negedge i_clock);
    check(retunes[15:0], 16'h0001);
    check({14'h0000, state}, 16'h0002);
    wr(7'h07, 8'h01);
    // loop on: drift limit is four times deviation 20h, halved first
    fifo_mode = 1'b0;
    wr(7'h1D, 8'hC0);
    wr(7'h07, 8'h05);
    wait_state(RADIO_RX);
    peak = 10'h000;
    repeat (300) @(negedge i_clock);
    check({6'h00, peak}, 16'h0040);
    wr(7'h1D, 8'h40);
    peak = 10'h000;
    repeat (300) @(negedge i_clock);
    check({6'h00, peak}, 16'h0080);
    // preamble comes only after the loop has run for many cycles
    pulse('{preamble_detect: 1'b1, packet_end: 1'b0, packet_valid: 1'b0, packet_error: 1'b0});
    repeat (2) @(negedge i_clock);
    held = lo_offset;
    repeat (20) @(negedge i_clock);
    check({6'h00, lo_offset}, {6'h00, held});
    rd_check(7'h73, held[7:0]);
    rd_check(7'h74, {6'h00, held[9:8]});
    multi_packet = 1'b1;
    afc_error = 10'h000;
    pulse('{preamble_detect: 1'b0, packet_end: 1'b1, packet_valid: 1'b0, packet_error: 1'b0});
    repeat (3) @(negedge i_clock);
    check({6'h00, lo_offset}, 16'h0000);
    conclude();
  end
endmodule // synth_offset_afc_control_tb
